/* dv/rnf_node_model.sv */
/*
  Behavioural model of the remote serial bus nodes that send request
  packets, plus the outside filter results that travel with them.
  Assumes the caller times each send from the bench clock.
*/
`timescale 1ns/1ps

module rnf_node_model (
  input  wire logic         clk,
  output logic              req_valid,
  output rnf_pkg::rnf_node_t req_src_node,
  output logic              req_src_local,
  output logic              req_to_phys,
  output logic              ext_async_accept,
  output logic              ext_phys_enable
);
  // Idle lines start low, no request pending
  initial begin
    req_valid        = 1'b0;
    req_src_node     = 6'h00;
    req_src_local    = 1'b0;
    req_to_phys      = 1'b0;
    ext_async_accept = 1'b0;
    ext_phys_enable  = 1'b0;
  end

  // One request for one cycle; afterwards the lines show inverted junk
  task automatic send(input rnf_pkg::rnf_node_t n, input logic loc, input logic ph,
                      input logic ea, input logic ep);
    @(posedge clk);
    req_valid        <= 1'b1;
    req_src_node     <= n;
    req_src_local    <= loc;
    req_to_phys      <= ph;
    ext_async_accept <= ea;
    ext_phys_enable  <= ep;
    @(posedge clk);
    req_valid        <= 1'b0;
    req_src_node     <= ~n;
    req_src_local    <= ~loc;
    req_to_phys      <= ~ph;
    ext_async_accept <= ~ea;
    ext_phys_enable  <= ~ep;
  endtask
endmodule

/* dv/tb.sv */
/*
  Self-checking bench for the receive request node filter.
  Assumes the node model drives the request side and the bench the registers.
*/
`timescale 1ns/1ps
`include "rnf_regs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module tb;
  logic               clk;        // Bench clock
  logic               rst_n;      // Async reset, active low
  logic               host_reset; // Bus host reset
  logic [11:0]        reg_addr;   // Register address
  logic [31:0]        reg_wdata;  // Register write data
  logic               reg_wr;     // Write strobe
  logic               reg_rd;     // Read strobe
  logic [31:0]        reg_rdata;  // Read data
  logic               req_valid;  // Request lines from the model
  rnf_pkg::rnf_node_t req_src_node;
  logic               req_src_local;
  logic               req_to_phys;
  logic               ext_async_accept;
  logic               ext_phys_enable;
  logic               dec_valid;  // Decision outputs
  logic               dec_accept;
  rnf_pkg::rnf_route_t dec_route;
  logic               phys_nonlocal_enable;
  int                 num_errors = 0;
  int                 compares   = 0;
  localparam rnf_pkg::rnf_route_t RT_DROP  = rnf_pkg::RNF_ROUTE_DROP;
  localparam rnf_pkg::rnf_route_t RT_ASYNC = rnf_pkg::RNF_ROUTE_ASYNC;
  localparam rnf_pkg::rnf_route_t RT_PHYS  = rnf_pkg::RNF_ROUTE_PHYS;
  localparam logic [31:0]         ACC_PAT  = 32'h5A5AC3C3;
  localparam logic [31:0]         EN_PAT   = 32'h2AAB0000;

  rnf_filter rnf_filter_inst (.clk(clk), .rst_n(rst_n), .host_reset(host_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req_src_node(req_src_node),
    .req_src_local(req_src_local), .req_to_phys(req_to_phys),
    .ext_async_accept(ext_async_accept), .ext_phys_enable(ext_phys_enable),
    .dec_valid(dec_valid), .dec_accept(dec_accept), .dec_route(dec_route),
    .phys_nonlocal_enable(phys_nonlocal_enable));

  rnf_node_model rnf_node_model_inst (.clk(clk), .req_valid(req_valid),
    .req_src_node(req_src_node), .req_src_local(req_src_local),
    .req_to_phys(req_to_phys), .ext_async_accept(ext_async_accept),
    .ext_phys_enable(ext_phys_enable));

  // Clock generator
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // Verdict and end of run
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // One-cycle register read, data judged in the following cycle
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(nm, ex, reg_rdata)
  endtask

  // One request and the decision one cycle later
  task automatic req(input int n, input logic loc, input logic ph, input logic ea,
                     input logic ep, input logic acc, input rnf_pkg::rnf_route_t rt);
    rnf_node_model_inst.send(6'(n), loc, ph, ea, ep);
    #1;
    `CHK("dec_valid", 1'b1, dec_valid)
    `CHK("dec_accept", acc, dec_accept)
    `CHK("dec_route", rt, dec_route)
  endtask

  // Reset values and an unmapped address
  task automatic t_reset();
    wr(12'h120, 32'hFFFFFFFF);
    rd(`RNF_ASYNC_LOW_SET, 32'h00000000, "accept reset");
    rd(`RNF_PHYS_HIGH_SET, 32'h00000000, "enable reset");
    rd(12'h120, 32'h00000000, "unmapped");
  endtask

  // Every low node against a mixed accept pattern
  task automatic t_async();
    wr(`RNF_ASYNC_LOW_SET, ACC_PAT);
    rd(`RNF_ASYNC_LOW_CLR, ACC_PAT, "accept via clear port");
    for (int n = 0; n < 32; n++) begin
      req(n, 1'b1, 1'b0, 1'b0, 1'b1, ACC_PAT[n], ACC_PAT[n] ? RT_ASYNC : RT_DROP);
    end
    wr(`RNF_ASYNC_LOW_CLR, 32'h0000FF00);
    rd(`RNF_ASYNC_LOW_SET, 32'h5A5A00C3, "accept after clear");
    req(14, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, RT_DROP);
  endtask

  // Upper nodes: physical or fallback, async check first
  task automatic t_phys();
    wr(`RNF_PHYS_HIGH_SET, EN_PAT);
    for (int n = 48; n < 63; n++) begin
      req(n, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, EN_PAT[n-32] ? RT_PHYS : RT_ASYNC);
    end
    req(49, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, RT_DROP);
    req(1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, RT_PHYS);
    req(63, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, RT_ASYNC);
    req(40, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, RT_ASYNC);
    wr(`RNF_PHYS_HIGH_CLR, 32'h00030000);
    rd(`RNF_PHYS_HIGH_SET, 32'h2AA80000, "partial clear");
  endtask

  // Nonlocal sources gated only by the all-bus bit
  task automatic t_nonlocal();
    req(0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, RT_DROP);
    wr(`RNF_PHYS_HIGH_SET, 32'h80000000);
    @(posedge clk);
    #1;
    `CHK("nonlocal enable", 1'b1, phys_nonlocal_enable)
    req(18, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, RT_PHYS);
    req(2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, RT_ASYNC);
  endtask

  // Host reset clears the filters but keeps the all-bus bit
  task automatic t_host();
    @(posedge clk);
    host_reset <= 1'b1;
    @(posedge clk);
    host_reset <= 1'b0;
    rd(`RNF_ASYNC_LOW_SET, 32'h00000000, "accept after host reset");
    rd(`RNF_PHYS_HIGH_CLR, 32'h80000000, "enable after host reset");
    req(20, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, RT_ASYNC);
    wr(`RNF_PHYS_HIGH_CLR, 32'h80000000);
    rd(`RNF_PHYS_HIGH_SET, 32'h00000000, "all cleared");
    #1;
    `CHK("decision pulse", 1'b0, dec_valid)
    `CHK("held accept", 1'b1, dec_accept)
    `CHK("held route", RT_ASYNC, dec_route)
  endtask

  // Power reset in mid-run clears the all-bus bit as well
  task automatic t_rst();
    wr(`RNF_PHYS_HIGH_SET, 32'h80000000);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(`RNF_PHYS_HIGH_SET, 32'h00000000, "enable after reset");
    `CHK("nonlocal after reset", 1'b0, phys_nonlocal_enable)
    `CHK("accept after reset", 1'b0, dec_accept)
  endtask

  // Main sequence
  initial begin
    rst_n      = 1'b0;
    host_reset = 1'b0;
    reg_addr   = 12'h000;
    reg_wdata  = 32'h00000000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_async();
    t_phys();
    t_nonlocal();
    t_host();
    t_rst();
    report_and_stop();
  end

  // Watchdog at 4000 cycles, far beyond the under two hundred cycles the run needs
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule

/* rtl/rnf_filter.sv */
/*
  Receive request node filter: the low asynchronous node-accept
  register, the high physical node-enable register with its nonlocal
  enable, a plain register port, and the per-request decision.
  Assumes requests and host reset come from logic on clk, and that
  the register master keeps strobes one cycle long and never both.
*/
//
// Behaviour
// - Low accept bit n gates node n requests
// - Bits 29..2 map to same-numbered node
// - High enable bit b (16..30) routes node b+32 physical
// - Physical packets check async, then physical
// - Physical bit clear sends to async context
// - Per-node physical compare only for local bus
// - Nonlocal packets unacknowledged unless bit 31
// - Bit 31 accepts nonlocal; host reset keeps it
// - High enable register is read/set/clear
`timescale 1ns/1ps
`include "rnf_regs.svh"

module rnf_filter (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                host_reset,
  input  wire logic [11:0]         reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  input  wire logic                req_valid,
  input  wire rnf_pkg::rnf_node_t  req_src_node,
  input  wire logic                req_src_local,
  input  wire logic                req_to_phys,
  input  wire logic                ext_async_accept,
  input  wire logic                ext_phys_enable,
  output logic                     dec_valid,
  output logic                     dec_accept,
  output rnf_pkg::rnf_route_t      dec_route,
  output logic                     phys_nonlocal_enable
);

  // Stored filter registers
  logic [31:0] async_node_accept_low;  // Per-node accept, nodes 0..31
  logic [31:0] phys_node_enable_high;  // Per-node physical, nodes 48..62

  // Write decodes of the four ports
  logic wr_async_set;  // Set port of the accept register
  logic wr_async_clr;  // Clear port of the accept register
  logic wr_phys_set;   // Set port of the enable register
  logic wr_phys_clr;   // Clear port of the enable register

  // Read decode result
  logic [31:0] next_rdata;  // Word that the read returns

  // Combinational decision for the current request
  rnf_pkg::rnf_route_t next_route;

  // Write strobes qualified by address
  assign wr_async_set = reg_wr && (reg_addr == `RNF_ASYNC_LOW_SET);
  assign wr_async_clr = reg_wr && (reg_addr == `RNF_ASYNC_LOW_CLR);
  assign wr_phys_set  = reg_wr && (reg_addr == `RNF_PHYS_HIGH_SET);
  assign wr_phys_clr  = reg_wr && (reg_addr == `RNF_PHYS_HIGH_CLR);

  // Per-bit set/clear storage for both registers
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_bit
      // Accept bit: set/clear writes first, then cleared by host reset
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          async_node_accept_low[gi] <= 1'(`RNF_ASYNC_LOW_RST >> gi);
        end else if (wr_async_set && reg_wdata[gi]) begin
          async_node_accept_low[gi] <= 1'b1;
        end else if (wr_async_clr && reg_wdata[gi]) begin
          async_node_accept_low[gi] <= 1'b0;
        end else if (host_reset) begin
          async_node_accept_low[gi] <= 1'b0;
        end
      end

      // Enable bit: bit 31 is kept across host reset
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          phys_node_enable_high[gi] <= 1'(`RNF_PHYS_HIGH_RST >> gi);
        end else if (wr_phys_set && reg_wdata[gi]) begin
          phys_node_enable_high[gi] <= 1'b1;
        end else if (wr_phys_clr && reg_wdata[gi]) begin
          phys_node_enable_high[gi] <= 1'b0;
        end else if (host_reset && (gi != `RNF_NONLOCAL_POS)) begin
          phys_node_enable_high[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read mux: set and clear ports both return the value
  always_comb begin
    unique case (reg_addr)
      `RNF_ASYNC_LOW_SET,
      `RNF_ASYNC_LOW_CLR: begin
        next_rdata = async_node_accept_low;
      end
      `RNF_PHYS_HIGH_SET,
      `RNF_PHYS_HIGH_CLR: begin
        next_rdata = phys_node_enable_high;
      end
      default: begin
        // Unmapped addresses read as zero
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Node comparison logic
  rnf_node_match u_match (
    .src_node              (req_src_node),
    .src_local             (req_src_local),
    .to_phys               (req_to_phys),
    .async_node_accept_low (async_node_accept_low),
    .phys_node_enable_high (phys_node_enable_high),
    .ext_async_accept      (ext_async_accept),
    .ext_phys_enable       (ext_phys_enable),
    .route                 (next_route)
  );

  // Decision valid pulse, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= req_valid;
    end
  end

  // Decision route and acknowledge, held until next request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_route  <= rnf_pkg::RNF_ROUTE_DROP;
      dec_accept <= 1'b0;
    end else if (req_valid) begin
      dec_route  <= next_route;
      dec_accept <= (next_route != rnf_pkg::RNF_ROUTE_DROP);
    end
  end

  // Next value of the nonlocal enable mirror
  logic next_nonlocal;
  assign next_nonlocal = phys_node_enable_high[`RNF_NONLOCAL_POS];

  // Mirror of the nonlocal enable for the link layer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phys_nonlocal_enable <= 1'b0;
    end else begin
      phys_nonlocal_enable <= next_nonlocal;
    end
  end

  // Checks on the decision path and the register port,
  // with covers of the main scenarios

  // Helper lookups sampled with the request
  logic chk_low_bit;   // Accept bit of a low node
  logic chk_high_bit;  // Enable bit of a high node
  logic chk_low_node;  // Request from a local node below 32
  logic chk_high_node; // Request from a local node 48..62
  logic [5:0] chk_off; // Node minus 32

  assign chk_off       = req_src_node - `RNF_PHYS_HIGH_BASE;
  assign chk_low_bit   = async_node_accept_low[req_src_node[4:0]];
  assign chk_high_bit  = phys_node_enable_high[chk_off[4:0]];
  assign chk_low_node  = req_src_local && (req_src_node < `RNF_LOW_LIMIT);
  assign chk_high_node = req_src_local && (req_src_node >= `RNF_PHYS_FIRST_NODE)
                         && (req_src_node <= `RNF_LAST_NODE);

  // Low node acceptance follows its accept bit
  AST_LOW_ACCEPT: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && chk_low_node |=> dec_valid && (dec_accept == $past(chk_low_bit))
  ) else $error("low node acceptance does not follow accept bit");

  // Mid low nodes use their own bit position
  AST_MID_BITS: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && chk_low_node && req_src_node >= 6'h02 && req_src_node <= 6'h1D
    && !chk_low_bit |=> dec_route == rnf_pkg::RNF_ROUTE_DROP
  ) else $error("node with clear accept bit was not dropped");

  // High node with accepted async and enable bit goes physical
  AST_HIGH_PHYS: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && chk_high_node && req_to_phys && ext_async_accept && chk_high_bit
    |=> dec_route == rnf_pkg::RNF_ROUTE_PHYS
  ) else $error("enabled high node not routed physical");

  // Physical route never without async acceptance
  AST_ASYNC_FIRST: assert property (
    @(posedge clk) disable iff (!rst_n)
    dec_valid && dec_route == rnf_pkg::RNF_ROUTE_PHYS |-> dec_accept && $past(req_to_phys)
  ) else $error("physical route without accepted physical request");

  // Clear enable bit falls back to async context
  AST_FALLBACK: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && chk_high_node && req_to_phys && ext_async_accept && !chk_high_bit
    |=> dec_route == rnf_pkg::RNF_ROUTE_ASYNC
  ) else $error("disabled high node not sent to async context");

  // Nonlocal route ignores node bits
  AST_NONLOCAL_CMP: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && !req_src_local && req_to_phys && next_nonlocal
    |=> dec_route == rnf_pkg::RNF_ROUTE_PHYS
  ) else $error("nonlocal request compared per node");

  // Nonlocal request dropped without bit 31
  AST_NONLOCAL_NACK: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && !req_src_local && !next_nonlocal |=> dec_valid && !dec_accept
  ) else $error("nonlocal packet acknowledged with bit 31 clear");

  // Host reset keeps bit 31, clears the rest
  AST_HOST_RESET: assert property (
    @(posedge clk) disable iff (!rst_n)
    host_reset && !reg_wr |=> (phys_node_enable_high[`RNF_NONLOCAL_POS]
      == $past(next_nonlocal)) && (phys_node_enable_high[30:0] == 31'h00000000)
      && (async_node_accept_low == 32'h00000000) ##1
      (phys_nonlocal_enable == $past(next_nonlocal, 2))
  ) else $error("host reset disturbed bit 31 or left bits set");

  // Set port of the enable register sets the written ones
  AST_SET_PORT: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_phys_set |=> (phys_node_enable_high & $past(reg_wdata)) == $past(reg_wdata)
  ) else $error("set port failed to set bits");

  // Clear port clears ones, keeps the rest
  AST_CLR_PORT: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_async_clr && !host_reset |=> async_node_accept_low
      == ($past(async_node_accept_low) & ~$past(reg_wdata))
  ) else $error("clear port result wrong");

  // Read returns stored word one cycle later
  AST_READ_BACK: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `RNF_PHYS_HIGH_CLR |=> reg_rdata == $past(phys_node_enable_high)
  ) else $error("read data does not match register");

  // Set port of the accept register sets the written ones
  AST_LOW_SET_PORT: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_async_set |=> (async_node_accept_low & $past(reg_wdata)) == $past(reg_wdata)
  ) else $error("accept set port failed to set bits");

  // Clear port of the enable register clears ones, keeps the rest
  AST_PHYS_CLR_PORT: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_phys_clr && !host_reset |=> phys_node_enable_high
      == ($past(phys_node_enable_high) & ~$past(reg_wdata))
  ) else $error("enable clear port result wrong");

  // Writes to unmapped addresses leave both registers alone
  AST_UNMAPPED_WR: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr && !(wr_async_set || wr_async_clr || wr_phys_set || wr_phys_clr) && !host_reset
    |=> $stable(async_node_accept_low) && $stable(phys_node_enable_high)
  ) else $error("unmapped write changed a register");

  // Read data returns to zero outside the read cycle
  AST_RDATA_IDLE: assert property (
    @(posedge clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 32'h00000000
  ) else $error("read data present without a read");

  // Upper local nodes take acceptance from the outside filter
  AST_UPPER_ACCEPT: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && req_src_local && req_src_node >= `RNF_LOW_LIMIT
    |=> dec_accept == $past(ext_async_accept)
  ) else $error("upper node acceptance does not follow outside filter");

  // Decision holds while no request arrives
  AST_DEC_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    !req_valid |=> $stable(dec_route) && $stable(dec_accept)
  ) else $error("decision changed without a request");

  // Only packets for the physical context may go physical
  AST_PHYS_NEEDS_REQ: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && !req_to_phys |=> dec_route != rnf_pkg::RNF_ROUTE_PHYS
  ) else $error("non-physical packet routed physical");

  // Lower physical half disabled keeps the request off the physical context
  AST_LOWER_PHYS: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && req_src_local && req_src_node < `RNF_PHYS_FIRST_NODE && !ext_phys_enable
    |=> dec_route != rnf_pkg::RNF_ROUTE_PHYS
  ) else $error("disabled lower node routed physical");

  // Broadcast node never reaches the physical context
  AST_BROADCAST: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && req_src_local && req_src_node == 6'h3F
    |=> dec_route != rnf_pkg::RNF_ROUTE_PHYS
  ) else $error("broadcast node routed physical");

  // Nonlocal packets for the async context are accepted with bit 31
  AST_NONLOCAL_ASYNC: assert property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && !req_src_local && !req_to_phys && next_nonlocal
    |=> dec_accept && dec_route == rnf_pkg::RNF_ROUTE_ASYNC
  ) else $error("nonlocal request refused with bit 31 set");

  // Mirror of bit 31 lags the register by one cycle
  AST_MIRROR: assert property (
    @(posedge clk) disable iff (!rst_n)
    phys_nonlocal_enable == $past(next_nonlocal)
  ) else $error("nonlocal enable mirror out of step");

  // Main scenarios
  COV_PHYS_ROUTE: cover property (
    @(posedge clk) disable iff (!rst_n)
    dec_valid && dec_route == rnf_pkg::RNF_ROUTE_PHYS);
  COV_FALLBACK: cover property (
    @(posedge clk) disable iff (!rst_n)
    dec_valid && $past(req_to_phys) && dec_route == rnf_pkg::RNF_ROUTE_ASYNC);
  COV_NONLOCAL_OK: cover property (
    @(posedge clk) disable iff (!rst_n)
    req_valid && !req_src_local ##1 dec_accept);
  COV_HOST_RESET_KEEP: cover property (
    @(posedge clk) disable iff (!rst_n)
    host_reset && next_nonlocal ##1 next_nonlocal);
  COV_DROP: cover property (
    @(posedge clk) disable iff (!rst_n)
    dec_valid && !dec_accept && dec_route == rnf_pkg::RNF_ROUTE_DROP);

endmodule

/* rtl/rnf_node_match.sv */
/*
  Combinational node comparison for one request: checks the source
  node against the asynchronous filters, then against the physical
  enables, and picks a destination context.
  Assumes all inputs are on the caller's clock and stable while used.
*/
`timescale 1ns/1ps
`include "rnf_regs.svh"

module rnf_node_match (
  input  wire rnf_pkg::rnf_node_t  src_node,
  input  wire logic                src_local,
  input  wire logic                to_phys,
  input  wire logic [31:0]         async_node_accept_low,
  input  wire logic [31:0]         phys_node_enable_high,
  input  wire logic                ext_async_accept,
  input  wire logic                ext_phys_enable,
  output rnf_pkg::rnf_route_t      route
);

  logic async_ok;   // Asynchronous filter passes
  logic phys_ok;    // Physical enable passes
  logic [5:0] high_idx;  // Node number minus 32

  // Offset of the node inside the high physical register
  assign high_idx = src_node - `RNF_PHYS_HIGH_BASE;

  // Asynchronous filter lookup
  always_comb begin
    if (!src_local) begin
      // Nonlocal source: only the all-buses bit decides
      async_ok = phys_node_enable_high[`RNF_NONLOCAL_POS];
    end else if (src_node < `RNF_LOW_LIMIT) begin
      // Nodes 0 to 31 come from the low accept register
      async_ok = async_node_accept_low[src_node[4:0]];
    end else begin
      // Upper nodes are filtered elsewhere
      async_ok = ext_async_accept;
    end
  end

  // Physical enable lookup, repeated after the async check
  always_comb begin
    if (!src_local) begin
      // No per-node comparison for a nonlocal source
      phys_ok = phys_node_enable_high[`RNF_NONLOCAL_POS];
    end else if (src_node >= `RNF_PHYS_FIRST_NODE && src_node <= `RNF_LAST_NODE) begin
      phys_ok = phys_node_enable_high[high_idx[4:0]];
    end else if (src_node < `RNF_PHYS_FIRST_NODE) begin
      // Lower physical half is held elsewhere
      phys_ok = ext_phys_enable;
    end else begin
      // Broadcast node never goes physical
      phys_ok = 1'b0;
    end
  end

  // Route choice: async first, physical second
  always_comb begin
    if (!async_ok) begin
      route = rnf_pkg::RNF_ROUTE_DROP;
    end else if (to_phys && phys_ok) begin
      route = rnf_pkg::RNF_ROUTE_PHYS;
    end else begin
      route = rnf_pkg::RNF_ROUTE_ASYNC;
    end
  end

endmodule

/* rtl/rnf_pkg.sv */
/*
  Types shared by the receive request node filter files.
  Assumes rnf_regs.svh supplies the numeric constants.
*/
package rnf_pkg;

  // Six-bit physical node number on the serial bus
  typedef logic [5:0] rnf_node_t;

  // Where an incoming request ends up
  typedef enum logic [1:0] {
    RNF_ROUTE_DROP  = 2'b00,
    RNF_ROUTE_ASYNC = 2'b01,
    RNF_ROUTE_PHYS  = 2'b10
  } rnf_route_t;

endpackage

/* rtl/rnf_regs.svh */
/*
  Register offsets, field positions and reset values of the receive
  request node filter. Assumes a 12-bit byte address on the register
  port and 32-bit data words.
*/
`ifndef RNF_REGS_SVH
`define RNF_REGS_SVH

// Byte offsets of the set and clear ports
`define RNF_ASYNC_LOW_SET   12'h108
`define RNF_ASYNC_LOW_CLR   12'h10C
`define RNF_PHYS_HIGH_SET   12'h110
`define RNF_PHYS_HIGH_CLR   12'h114

// Reset values
`define RNF_ASYNC_LOW_RST   32'h00000000
`define RNF_PHYS_HIGH_RST   32'h00000000

// Field positions
`define RNF_NONLOCAL_BIT    5
`define RNF_NONLOCAL_POS    31
`define RNF_PHYS_HIGH_BASE  6'h20
`define RNF_PHYS_FIRST_NODE 6'h30
`define RNF_LAST_NODE       6'h3E
`define RNF_LOW_LIMIT       6'h20

`endif
